//--- src/mdc_hw_config_regs.sv
/*
 Hardware configuration register bank with its own serial target,
 brake and command source selection, frequency duty divider and
 sleep entry timer.
 Assumes scl and sda are synchronous to ref_clk and slow against it.
*/
// What this block does
// - Brake override 0h or 3h: braking follows the hardware brake pin.
// - Override 1h: pin ignored, brake or align per brake style bit.
// - Override 2h: pin ignored, neither brake nor align.
// - Brake style bit: clear low-side braking, set align braking.
// - Rate source picks analog, PWM duty, serial value or frequency.
// - Monitor routing picks second DAC or phase A, B, C sense.
// - Bit 27 enables both DAC monitor pins.
// - Bits 4-3 set serial pin drive strength code.
// - Bit 2 enables pull-ups on fault and rotation pins.
// - Bus voltage range 15, 30, 60 V; code 3h undefined.
// - Frequency mode duty is measured frequency over full-scale field.
// - Sleep after command held low for coded time.
// - Bit 13 turns on dynamic current gain.
// - Bit 12 turns on dynamic voltage gain.
// - Bit 11 picks standby or sleep for idle.
// - Bits 10-9 pick clock source; code 2h not applicable.
// - Bit 8 enables external clock mode.
`timescale 1ns/1ns
`default_nettype none
`include "mdc_params.svh"
module mdc_hw_config_regs
	import mdc_pkg::*;
#(
	parameter int CMD_W = 8,
	parameter int SLP_CYC0 = `MDC_CYC(`MDC_SLP0_NS),
	parameter int SLP_CYC1 = `MDC_CYC(`MDC_SLP1_NS),
	parameter int SLP_CYC2 = `MDC_CYC(`MDC_SLP2_NS),
	parameter int SLP_CYC3 = `MDC_CYC(`MDC_SLP3_NS)
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial configuration bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Brake
	input wire logic brake_pin_in,
	output logic brake_engage,
	output logic brake_align,
	// Motor command
	input wire logic [CMD_W-1:0] analog_cmd,
	input wire logic [CMD_W-1:0] pwm_cmd,
	input wire logic [CMD_W-1:0] digital_cmd,
	input wire logic [14:0] measured_freq,
	output logic [CMD_W-1:0] freq_duty,
	output logic [CMD_W-1:0] motor_cmd,
	// Sleep entry
	input wire logic cmd_below_sleep,
	output logic sleep_due,
	output logic idle_is_sleep,
	// Monitor and pin setup
	output logic [1:0] monitor2_source,
	output logic monitor_outputs_on,
	output logic [1:0] i2c_drive_code,
	output logic pullup_on,
	// Analog and clock setup
	output logic [1:0] bus_voltage_range,
	output logic bus_voltage_undef,
	output logic auto_current_gain_on,
	output logic auto_voltage_gain_on,
	output logic [1:0] clock_source,
	output logic clock_source_na,
	output logic outside_clock_on
);

	localparam int CNT_W = 28;

	// Refuse settings the logic cannot serve
	generate
		if (CMD_W < 2 || CMD_W > 16)
		begin : g_chk_w
			$error("CMD_W must be 2 to 16");
		end
		if (SLP_CYC0 < 1 || SLP_CYC3 >= (1 << CNT_W))
		begin : g_chk_s
			$error("sleep counts out of range");
		end
	endgenerate

	mdc_word_t pin_q, ifa_q, clk_q;
	mdc_i2c_e st_q;
	logic scl_q, sda_q, drive_q, rw_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_q;
	logic [1:0] lane_q;
	logic [23:0] wbuf_q;
	logic commit;
	mdc_word_t wword;

	// Bus edges, taken from the previous sample of each line
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
	wire bus_stop = scl_in & scl_q & ~sda_q & sda_in;
	wire [7:0] in_byte = {sh_q[6:0], sda_in};

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Read word by offset; unmapped offsets read zero
	function automatic mdc_word_t rd_word(input logic [7:0] p);
		rd_word = `MDC_RST_VAL;
		if (p == `MDC_OFS_PIN)
			rd_word = pin_q;
		else if (p == `MDC_OFS_IFA)
			rd_word = ifa_q;
		else if (p == `MDC_OFS_CLK)
			rd_word = clk_q;
	endfunction

	// Next read byte: lane 0 after the address, the following lane after a host ACK
	logic [1:0] rd_lane;
	mdc_word_t rd_w;
	logic [7:0] rd_next;
	assign rd_lane = (st_q == MDC_RACK) ? lane_q + 2'h1 : 2'h0;
	assign rd_w = rd_word(ptr_q);
	assign rd_next = rd_w[8*rd_lane +: 8];

	// Fourth byte of a write completes the word, low byte first
	assign commit = (st_q == MDC_WR) && scl_fall && (bit_q == `MDC_BITS)
		&& (lane_q == `MDC_LAST_LANE);
	assign wword = {sh_q, wbuf_q};

	// Serial target; start and stop win over any bit in flight
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_q <= MDC_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			lane_q <= 2'h0;
			wbuf_q <= 24'h000000;
			rw_q <= 1'b0;
			drive_q <= 1'b0;
		end
		else if (bus_start)
		begin
			st_q <= MDC_ADDR;
			bit_q <= 4'h0;
			drive_q <= 1'b0;
		end
		else if (bus_stop)
		begin
			st_q <= MDC_IDLE;
			drive_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				MDC_IDLE:
				begin
					drive_q <= 1'b0;
				end
				MDC_ADDR, MDC_PTR, MDC_WR:
				begin
					if (scl_rise)
					begin
						sh_q <= in_byte;
						bit_q <= bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == `MDC_BITS)
					begin
						bit_q <= 4'h0;
						drive_q <= 1'b1;
						if (st_q == MDC_ADDR)
						begin
							// Answer only our own address
							if (sh_q[7:1] == ifa_q[`MDC_ADR_HI:`MDC_ADR_LO])
							begin
								rw_q <= sh_q[0];
								lane_q <= 2'h0;
								st_q <= MDC_AACK;
							end
							else
							begin
								drive_q <= 1'b0;
								st_q <= MDC_IDLE;
							end
						end
						else if (st_q == MDC_PTR)
						begin
							ptr_q <= sh_q;
							lane_q <= 2'h0;
							st_q <= MDC_PACK;
						end
						else
						begin
							if (lane_q != `MDC_LAST_LANE)
								wbuf_q[8*lane_q +: 8] <= sh_q;
							lane_q <= lane_q + 2'h1;
							st_q <= MDC_WACK;
						end
					end
				end
				MDC_AACK:
				begin
					if (scl_fall && rw_q)
					begin
						sh_q <= rd_next;
						drive_q <= ~rd_next[7];
						bit_q <= 4'h1;
						st_q <= MDC_RD;
					end
					else if (scl_fall)
					begin
						drive_q <= 1'b0;
						st_q <= MDC_PTR;
					end
				end
				MDC_PACK, MDC_WACK:
				begin
					if (scl_fall)
					begin
						drive_q <= 1'b0;
						st_q <= MDC_WR;
					end
				end
				MDC_RD:
				begin
					if (scl_fall && bit_q == `MDC_BITS)
					begin
						// Let go so the host can acknowledge
						drive_q <= 1'b0;
						st_q <= MDC_RACK;
					end
					else if (scl_fall)
					begin
						sh_q <= {sh_q[6:0], 1'b0};
						drive_q <= ~sh_q[6];
						bit_q <= bit_q + 4'h1;
					end
				end
				MDC_RACK:
				begin
					if (scl_rise && sda_in)
						st_q <= MDC_IDLE;
					else if (scl_fall)
					begin
						sh_q <= rd_next;
						drive_q <= ~rd_next[7];
						lane_q <= lane_q + 2'h1;
						bit_q <= 4'h1;
						st_q <= MDC_RD;
					end
				end
				default:
				begin
					st_q <= MDC_IDLE;
				end
			endcase
		end
	end

	// Open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = drive_q;

	// Register store; every bit kept, reserved ones included
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_q <= `MDC_RST_VAL;
			ifa_q <= `MDC_RST_VAL;
			clk_q <= `MDC_RST_VAL;
		end
		else if (commit)
		begin
			if (ptr_q == `MDC_OFS_PIN)
				pin_q <= wword;
			else if (ptr_q == `MDC_OFS_IFA)
				ifa_q <= wword;
			else if (ptr_q == `MDC_OFS_CLK)
				clk_q <= wword;
		end
	end

	// Brake decision from pin or override
	wire [1:0] brk = pin_q[`MDC_BRK_HI:`MDC_BRK_LO];
	assign brake_engage = (brk == `MDC_BRK_FORCE) ? 1'b1 :
		(brk == `MDC_BRK_NONE) ? 1'b0 : brake_pin_in;
	assign brake_align = brake_engage & pin_q[`MDC_STYLE];

	// Frequency duty divider, one quotient bit per clock
	wire [14:0] fs = clk_q[`MDC_FS_HI:`MDC_FS_LO];
	logic div_busy_q;
	logic [15:0] rem_q;
	logic [CMD_W-1:0] quo_q;
	logic [4:0] dcnt_q;
	logic [CMD_W-1:0] duty_q;
	wire [15:0] rem2 = {rem_q[14:0], 1'b0};
	wire take = rem2 >= {1'b0, fs};

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			div_busy_q <= 1'b0;
			rem_q <= 16'h0000;
			quo_q <= '0;
			dcnt_q <= 5'h00;
			duty_q <= '0;
		end
		else if (!div_busy_q)
		begin
			// Full scale or beyond, or no scale set, reads as full duty
			if (fs == 15'h0000 || measured_freq >= fs)
				duty_q <= '1;
			else
			begin
				rem_q <= {1'b0, measured_freq};
				quo_q <= '0;
				dcnt_q <= 5'(CMD_W);
				div_busy_q <= 1'b1;
			end
		end
		else
		begin
			rem_q <= take ? 16'(rem2 - {1'b0, fs}) : rem2;
			quo_q <= {quo_q[CMD_W-2:0], take};
			dcnt_q <= dcnt_q - 5'h01;
			if (dcnt_q == 5'h01)
			begin
				duty_q <= {quo_q[CMD_W-2:0], take};
				div_busy_q <= 1'b0;
			end
		end
	end
	assign freq_duty = duty_q;

	// Command source select, registered
	logic [CMD_W-1:0] cmd_q;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cmd_q <= '0;
		else
		begin
			unique case (pin_q[`MDC_RATE_HI:`MDC_RATE_LO])
				`MDC_RATE_ANA: cmd_q <= analog_cmd;
				`MDC_RATE_PWM: cmd_q <= pwm_cmd;
				`MDC_RATE_DIG: cmd_q <= digital_cmd;
				`MDC_RATE_FRQ: cmd_q <= duty_q;
			endcase
		end
	end
	assign motor_cmd = cmd_q;

	// Sleep entry timer; the command rising out of the sleep range restarts it
	logic [CNT_W-1:0] scnt_q, slim;
	logic due_q;
	always_comb
	begin
		unique case (clk_q[`MDC_SLP_HI:`MDC_SLP_LO])
			2'h0: slim = CNT_W'(SLP_CYC0);
			2'h1: slim = CNT_W'(SLP_CYC1);
			2'h2: slim = CNT_W'(SLP_CYC2);
			2'h3: slim = CNT_W'(SLP_CYC3);
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || !cmd_below_sleep)
		begin
			scnt_q <= '0;
			due_q <= 1'b0;
		end
		else if (scnt_q >= slim - CNT_W'(1))
			due_q <= 1'b1;
		else
			scnt_q <= scnt_q + CNT_W'(1);
	end
	assign sleep_due = due_q;
	assign idle_is_sleep = clk_q[`MDC_LPM];

	// Plain setting outputs straight from the register flops
	assign monitor2_source = ifa_q[`MDC_MON_HI:`MDC_MON_LO];
	assign monitor_outputs_on = ifa_q[`MDC_DAC];
	assign i2c_drive_code = ifa_q[`MDC_DRV_HI:`MDC_DRV_LO];
	assign pullup_on = ifa_q[`MDC_PU];
	assign bus_voltage_range = ifa_q[`MDC_BUS_HI:`MDC_BUS_LO];
	// Undefined range is flagged, not corrected; software must avoid it
	assign bus_voltage_undef = bus_voltage_range == `MDC_BUS_UNDEF;
	assign auto_current_gain_on = clk_q[`MDC_CG];
	assign auto_voltage_gain_on = clk_q[`MDC_VG];
	assign clock_source = clk_q[`MDC_CS_HI:`MDC_CS_LO];
	assign clock_source_na = clock_source == `MDC_CS_NA;
	// The reference rate itself is the host's to match
	assign outside_clock_on = clk_q[`MDC_XC];

endmodule
`default_nettype wire

//--- pkg/mdc_params.svh
/*
 Constants for the motor driver configuration register bank:
 offsets, field positions, codes and timings.
 Assumes it is included by its bare name before use.
*/
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH
// Register offsets and reset value
`define MDC_OFS_PIN 8'ha4
`define MDC_OFS_IFA 8'ha6
`define MDC_OFS_CLK 8'ha8
`define MDC_RST_VAL 32'h00000000
// Input pin setup fields
`define MDC_BRK_HI 3
`define MDC_BRK_LO 2
`define MDC_STYLE 5
`define MDC_RATE_HI 1
`define MDC_RATE_LO 0
`define MDC_BRK_FORCE 2'h1
`define MDC_BRK_NONE 2'h2
`define MDC_RATE_ANA 2'h0
`define MDC_RATE_PWM 2'h1
`define MDC_RATE_DIG 2'h2
`define MDC_RATE_FRQ 2'h3
// Interface setup fields
`define MDC_MON_HI 29
`define MDC_MON_LO 28
`define MDC_DAC 27
`define MDC_ADR_HI 26
`define MDC_ADR_LO 20
`define MDC_DRV_HI 4
`define MDC_DRV_LO 3
`define MDC_PU 2
`define MDC_BUS_HI 1
`define MDC_BUS_LO 0
`define MDC_BUS_UNDEF 2'h3
// Clock and sleep setup fields
`define MDC_FS_HI 30
`define MDC_FS_LO 16
`define MDC_SLP_HI 15
`define MDC_SLP_LO 14
`define MDC_CG 13
`define MDC_VG 12
`define MDC_LPM 11
`define MDC_CS_HI 10
`define MDC_CS_LO 9
`define MDC_XC 8
`define MDC_CS_NA 2'h2
// Serial framing
`define MDC_BITS 4'h8
`define MDC_LAST_LANE 2'h3
// Timing, times in ns
`define MDC_CLK_NS 100
`define MDC_SLP0_NS 50000
`define MDC_SLP1_NS 200000
`define MDC_SLP2_NS 20000000
`define MDC_SLP3_NS 200000000
`define MDC_CYC(t) (((t) + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`endif

//--- pkg/mdc_pkg.sv
/*
 Types for the motor driver configuration register bank.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package mdc_pkg;
	// Serial target states, Gray coded along the write path and the read byte loop
	typedef enum logic [3:0]
	{
		MDC_IDLE = 4'h0,
		MDC_ADDR = 4'h1,
		MDC_AACK = 4'h3,
		MDC_PTR = 4'h2,
		MDC_PACK = 4'h6,
		MDC_WR = 4'h7,
		MDC_WACK = 4'h5,
		MDC_RD = 4'h4,
		MDC_RACK = 4'hc
	} mdc_i2c_e;
	typedef logic [31:0] mdc_word_t;
endpackage
`default_nettype wire

//--- sim/mdc_hw_config_regs_properties.sv
/*
 Port checker for mdc_hw_config_regs.
 Assumes it is bound to every instance and sees only the ports.
*/
`timescale 1ns/1ns
`default_nettype none
module mdc_hw_config_regs_properties
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial bus
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Brake and sleep
	input wire logic brake_engage,
	input wire logic brake_align,
	input wire logic cmd_below_sleep,
	input wire logic sleep_due,
	// Settings
	input wire logic idle_is_sleep,
	input wire logic [1:0] monitor2_source,
	input wire logic [1:0] bus_voltage_range,
	input wire logic bus_voltage_undef,
	input wire logic [1:0] clock_source,
	input wire logic clock_source_na
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Serial clock fell one cycle ago
	sequence s_scl_fell;
		$past(scl_in, 2) && !$past(scl_in);
	endsequence
	// Command low one cycle ago and three cycles ago
	sequence s_low_held;
		$past(cmd_below_sleep) && $past(cmd_below_sleep, 3);
	endsequence
	property p_undef;
		bus_voltage_undef == (bus_voltage_range == 2'h3);
	endproperty
	a_undef: assert property (p_undef) else $error("range flag wrong");
	property p_na;
		clock_source_na == (clock_source == 2'h2);
	endproperty
	a_na: assert property (p_na) else $error("clock flag wrong");
	property p_align;
		brake_align |-> brake_engage;
	endproperty
	a_align: assert property (p_align) else $error("align without brake");
	property p_sleep_rise;
		$rose(sleep_due) |-> s_low_held;
	endproperty
	a_sleep_rise: assert property (p_sleep_rise) else $error("early sleep");
	property p_sleep_fall;
		!cmd_below_sleep |=> !sleep_due;
	endproperty
	a_sleep_fall: assert property (p_sleep_fall) else $error("sleep held");
	property p_oe_rise;
		$rose(sda_oe) |-> s_scl_fell;
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive off slot");
	// Our data line only moves while the serial clock is low
	property p_sda_out;
		$changed(sda_oe) |-> !scl_in && sda_out == 1'b0;
	endproperty
	a_sda_out: assert property (p_sda_out) else $error("sda not open drain");
	// Settings change only at a word end, while the serial clock is low
	property p_settings;
		$changed({monitor2_source, bus_voltage_range, clock_source, idle_is_sleep}) |-> !scl_in;
	endproperty
	a_settings: assert property (p_settings) else $error("stray update");
endmodule
bind mdc_hw_config_regs mdc_hw_config_regs_properties u_props
(
	.ref_clk, .rst, .scl_in, .sda_out, .sda_oe, .brake_engage, .brake_align,
	.cmd_below_sleep, .sleep_due, .idle_is_sleep, .monitor2_source, .bus_voltage_range,
	.bus_voltage_undef, .clock_source, .clock_source_na
);
`default_nettype wire

//--- sim/mdc_i2c_host.sv
/*
 Behavioural serial bus host for the configuration bank.
 Assumes an open-drain wire with a pull-up resolved by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module mdc_i2c_host
#(
	parameter int H = 2
)
(
	// Clock
	input wire logic ref_clk,
	// Open-drain bus
	input wire logic sda_in,
	output var logic scl,
	output var logic sda_low
);
	// Lines idle high
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One phase: both lines change only just after an edge
	task automatic ph(input logic s, input logic c);
		repeat (H) @(posedge ref_clk);
		sda_low <= s;
		scl <= c;
	endtask
	// Data set while low, sampled halfway through the high phase
	task automatic xbit(input logic b, output logic r);
		ph(!b, 1'b0);
		ph(!b, 1'b1);
		ph(!b, 1'b1);
		r = sda_in;
		ph(!b, 1'b0);
	endtask
	task automatic start();
		ph(1'b0, scl);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic nine, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], q[i]);
		xbit(nine, r);
		ack = !r;
	endtask
	// Whole word, lowest byte first; a read ends with a refusal of the last byte
	task automatic xfer(input logic [6:0] a, input logic [7:0] o, input logic [31:0] d,
		input logic rd, output logic [31:0] q, output logic ok);
		logic k;
		start();
		xbyte({a, 1'b0}, 1'b1, q[7:0], ok);
		xbyte(o, 1'b1, q[7:0], k);
		ok &= k;
		if (rd)
		begin
			start();
			xbyte({a, 1'b1}, 1'b1, q[7:0], k);
			ok &= k;
		end
		for (int i = 0; i < 4; i++)
			xbyte(rd ? 8'hff : d[8*i+:8], rd ? (i == 3) : 1'b1, q[8*i+:8], k);
		ok &= rd | k;
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
	endtask
endmodule
`default_nettype wire

//--- sim/tb_mdc_hw_config_regs.sv
/*
 Bench for the configuration bank, driven over the serial bus.
 Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_mdc_hw_config_regs;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic brake_pin_in = 1'b0;
	logic cmd_below_sleep = 1'b0;
	logic [7:0] analog_cmd = 8'h11;
	logic [7:0] pwm_cmd = 8'h22;
	logic [7:0] digital_cmd = 8'h33;
	logic [14:0] measured_freq = 15'h0032;
	logic scl, sda_low, sda_oe, ok, brake_engage, brake_align, sleep_due, idle_is_sleep;
	logic monitor_outputs_on, pullup_on, bus_voltage_undef, auto_current_gain_on;
	logic auto_voltage_gain_on, clock_source_na, outside_clock_on;
	logic [1:0] monitor2_source, i2c_drive_code, bus_voltage_range, clock_source;
	logic [7:0] freq_duty, motor_cmd;
	logic [31:0] rv, w;
	logic [6:0] adr = 7'h00;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	// Pull-up wins unless someone pulls low
	wire logic sda = !(sda_low | sda_oe);
	always #50 ref_clk = ~ref_clk;
	// Short sleep counts keep the run brief
	mdc_hw_config_regs #(.CMD_W(8), .SLP_CYC0(4), .SLP_CYC1(8), .SLP_CYC2(16), .SLP_CYC3(32)) dut
	(
		.ref_clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .brake_pin_in,
		.brake_engage, .brake_align, .analog_cmd, .pwm_cmd, .digital_cmd, .measured_freq,
		.freq_duty, .motor_cmd, .cmd_below_sleep, .sleep_due, .idle_is_sleep, .monitor2_source,
		.monitor_outputs_on, .i2c_drive_code, .pullup_on, .bus_voltage_range, .bus_voltage_undef,
		.auto_current_gain_on, .auto_voltage_gain_on, .clock_source, .clock_source_na,
		.outside_clock_on
	);
	mdc_i2c_host host (.ref_clk, .sda_in(sda), .scl, .sda_low);
	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		host.xfer(adr, o, d, 1'b0, rv, ok);
		chk(ok, 1);
	endtask
	task automatic rd(input logic [7:0] o, input logic [31:0] e);
		host.xfer(adr, o, 32'h0, 1'b1, rv, ok);
		chk(ok, 1);
		chk(rv, e);
	endtask
	// A hang is cut short well beyond the expected run length
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			failures++;
			finish_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		tick(2);
		chk(freq_duty, 8'hff);
		rd(8'ha4, 32'h0);
		rd(8'ha6, 32'h0);
		rd(8'ha8, 32'h0);
		$display("test reset done");
		for (int ov = 0; ov < 4; ov++)
			for (int st = 0; st < 2; st++)
			begin
				wr(8'ha4, {26'h0, st[0], 1'b0, ov[1:0], 2'h0});
				for (int p = 0; p < 2; p++)
				begin
					@(posedge ref_clk) brake_pin_in <= p[0];
					tick(1);
					chk(brake_engage, (ov == 1) ? 1 : (ov == 2) ? 0 : p);
					chk(brake_align, (ov == 1 || (ov != 2 && p == 1)) && st == 1);
				end
			end
		$display("test brake done");
		wr(8'ha8, {1'b0, 15'd200, 16'h0});
		tick(30);
		chk(freq_duty, 8'h40);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'ha4, {30'h0, c[1:0]});
			tick(2);
			chk(motor_cmd, (c == 3) ? 8'h40 : 8'h11 * (c + 1));
		end
		@(posedge ref_clk) measured_freq <= 15'd300;
		tick(30);
		chk(freq_duty, 8'hff);
		$display("test command done");
		for (int c = 0; c < 4; c++)
		begin
			w = {2'h0, c[1:0], c[0], 7'h2a, 15'h0, c[1:0], c[1], c[1:0]};
			wr(8'ha6, w);
			adr = 7'h2a;
			tick(1);
			chk(monitor2_source, c);
			chk(monitor_outputs_on, c[0]);
			chk(i2c_drive_code, c);
			chk(pullup_on, c[1]);
			chk({bus_voltage_undef, bus_voltage_range}, (c == 3) ? 7 : c);
		end
		rd(8'ha6, w);
		host.xfer(7'h00, 8'ha6, 32'h0, 1'b1, rv, ok);
		chk(ok, 0);
		wr(8'haa, 32'h12345678);
		rd(8'haa, 32'h0);
		$display("test interface done");
		for (int c = 0; c < 4; c++)
		begin
			w = {1'b1, 15'd200, c[1:0], c[0], c[1], c[0], c[1:0], c[1], 8'h0};
			wr(8'ha8, w);
			rd(8'ha8, w);
			chk(auto_current_gain_on, c[0]);
			chk(auto_voltage_gain_on, c[1]);
			chk(idle_is_sleep, c[0]);
			chk({clock_source_na, clock_source}, {c == 2, c[1:0]});
			chk(outside_clock_on, c[1]);
			@(posedge ref_clk) cmd_below_sleep <= 1'b1;
			n = 0;
			while (sleep_due !== 1'b1 && n < 100)
			begin
				tick(1);
				n++;
			end
			chk(n, 4 << c);
			@(posedge ref_clk) cmd_below_sleep <= 1'b0;
			tick(2);
			chk(sleep_due, 0);
		end
		$display("test clock and sleep done");
		// Reset again mid-run: settings and our address fall back to zero
		@(posedge ref_clk) rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		tick(2);
		adr = 7'h00;
		chk(freq_duty, 8'hff);
		chk(monitor2_source, 0);
		rd(8'ha6, 32'h0);
		rd(8'ha8, 32'h0);
		$display("test second reset done");
		finish_test();
	end
endmodule
`default_nettype wire
